// [core/mdl_pkg.sv]
/*
  Package for the host-side load port controller of a 16-channel 8-bit converter.
  Assumes a single 40 MHz clock domain.
*/
package mdl_pkg;
  localparam int unsigned MDL_CHANNELS      = 16;
  localparam int unsigned MDL_DATA_W        = 8;
  localparam int unsigned MDL_ADDR_W        = 4;
  localparam int unsigned MDL_CLK_PERIOD_NS = 25;
  // Least strobe low width in ns
  localparam int unsigned MDL_STROBE_NS     = 40;
  localparam int unsigned MDL_STROBE_CYC    =
    (MDL_STROBE_NS + MDL_CLK_PERIOD_NS - 1) / MDL_CLK_PERIOD_NS;
  // Setup and hold around strobe edges, one cycle each
  localparam int unsigned MDL_SETUP_CYC     = 1;
  localparam int unsigned MDL_HOLD_CYC      = 1;
  localparam logic [MDL_DATA_W-1:0] MDL_CLEAR_CODE = 8'h00;
  typedef enum logic [1:0] {
    MDL_OP_WRITE,
    MDL_OP_LOAD,
    MDL_OP_READ,
    MDL_OP_CLEAR
  } mdl_op_t;
endpackage

// [core/mdl_cnt.sv]
/*
  Down counter used to time each pin phase.
  Assumes a single clock domain.
*/
`timescale 1ns/1ps
module mdl_cnt #(
  parameter int unsigned W = 4
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              done
);
  logic [W-1:0] count;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (load) begin
      count <= value;
    end else if (count != '0) begin
      count <= count - W'(1);
    end
  end

  // Count only, so load may depend on done without a loop
  assign done = (count == '0);
endmodule

// [core/mdl_host.sv]
/*
  Host controller that drives the parallel load port of a 16-channel 8-bit converter:
  channel writes, common load, readback and clear.
  Assumes device pins sampled synchronously to mclk; data bus is split into in/out/oe_n.
*/
// Behaviour
// - Each code goes on an 8-bit data bus with a 4-bit address picking one channel.
// - Exactly one input register is written per write cycle.
// - With read/write low, data is captured on the rising edge of the write strobe.
// - Strobe together with load low copies all input registers to converter registers.
`timescale 1ns/1ps
module mdl_host
  import mdl_pkg::*;
#(
  parameter int unsigned STROBE_CYC = MDL_STROBE_CYC
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  req_valid,
  output logic                       req_ready,
  input  wire mdl_op_t               req_op,
  input  wire logic [MDL_ADDR_W-1:0] req_addr,
  input  wire logic [MDL_DATA_W-1:0] req_data,
  output logic                       rsp_valid,
  output logic [MDL_DATA_W-1:0]      rsp_data,
  output logic                       select_n,
  output logic                       strobe_n,
  output logic                       read_write,
  output logic                       transfer_load_n,
  output logic                       clear_outputs_n,
  output logic [MDL_ADDR_W-1:0]      addr,
  output logic [MDL_DATA_W-1:0]      data_out,
  output logic                       data_oe_n,
  input  wire logic [MDL_DATA_W-1:0] data_in
);
  typedef enum logic [2:0] {
    MDL_IDLE,
    MDL_SETUP,
    MDL_PULSE,
    MDL_HOLD
  } mdl_state_t;

  mdl_state_t state;
  mdl_op_t    op;
  logic       cnt_load;
  logic [3:0] cnt_value;
  logic       cnt_done;

  mdl_cnt #(.W(4)) u_cnt (
    .mclk  (mclk),
    .rst_n (rst_n),
    .load  (cnt_load),
    .value (cnt_value),
    .done  (cnt_done)
  );

  assign req_ready = (state == MDL_IDLE);

  always_comb begin
    cnt_load  = 1'b0;
    cnt_value = 4'h0;
    case (state)
      MDL_IDLE: begin
        if (req_valid) begin
          cnt_load  = 1'b1;
          // A phase of N cycles loads N-1
          cnt_value = 4'(MDL_SETUP_CYC - 1);
        end
      end
      MDL_SETUP: begin
        if (cnt_done) begin
          cnt_load  = 1'b1;
          cnt_value = 4'(STROBE_CYC - 1);
        end
      end
      MDL_PULSE: begin
        if (cnt_done) begin
          cnt_load  = 1'b1;
          cnt_value = 4'(MDL_HOLD_CYC - 1);
        end
      end
      default: begin
        cnt_load  = 1'b0;
        cnt_value = 4'h0;
      end
    endcase
  end

  // Phase sequencing
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= MDL_IDLE;
    end else begin
      case (state)
        MDL_IDLE:  if (req_valid) state <= MDL_SETUP;
        MDL_SETUP: if (cnt_done) state <= MDL_PULSE;
        MDL_PULSE: if (cnt_done) state <= MDL_HOLD;
        MDL_HOLD:  if (cnt_done) state <= MDL_IDLE;
        default:   state <= MDL_IDLE;
      endcase
    end
  end

  // Request capture: address and data held over the whole cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      op       <= MDL_OP_WRITE;
      addr     <= '0;
      data_out <= '0;
    end else if (state == MDL_IDLE && req_valid) begin
      op       <= req_op;
      addr     <= req_addr;
      data_out <= req_data;
    end
  end

  // Pin drive
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      select_n        <= 1'b1;
      strobe_n        <= 1'b1;
      read_write      <= 1'b1;
      transfer_load_n <= 1'b1;
      clear_outputs_n <= 1'b1;
      data_oe_n       <= 1'b1;
    end else begin
      case (state)
        MDL_IDLE: begin
          select_n        <= !req_valid || (req_op == MDL_OP_CLEAR);
          read_write      <= !(req_valid && req_op == MDL_OP_WRITE);
          data_oe_n       <= !(req_valid && req_op == MDL_OP_WRITE);
          strobe_n        <= 1'b1;
          transfer_load_n <= 1'b1;
          clear_outputs_n <= 1'b1;
        end
        MDL_SETUP: begin
          if (cnt_done) begin
            if (op == MDL_OP_CLEAR) begin
              clear_outputs_n <= 1'b0;
            end else begin
              strobe_n <= 1'b0;
              transfer_load_n <= (op != MDL_OP_LOAD);
            end
          end
        end
        MDL_PULSE: begin
          if (cnt_done) begin
            strobe_n        <= 1'b1;
            transfer_load_n <= 1'b1;
            clear_outputs_n <= 1'b1;
          end
        end
        MDL_HOLD: begin
          if (cnt_done) begin
            select_n   <= 1'b1;
            read_write <= 1'b1;
            data_oe_n  <= 1'b1;
          end
        end
        default: begin
          select_n <= 1'b1;
          strobe_n <= 1'b1;
        end
      endcase
    end
  end

  // Readback sampled just before the strobe rises
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
    end else begin
      rsp_valid <= 1'b0;
      if (state == MDL_PULSE && cnt_done && op == MDL_OP_READ) begin
        rsp_valid <= 1'b1;
        rsp_data  <= data_in;
      end
    end
  end

  AST_WRITE_DRIVES: assert property (@(posedge mclk) disable iff (!rst_n)
    (!strobe_n && !read_write) |-> !data_oe_n && !select_n)
    else $error("write strobe without driven data");
  AST_READ_RELEASES: assert property (@(posedge mclk) disable iff (!rst_n)
    read_write |-> data_oe_n)
    else $error("bus driven during read");
  AST_STROBE_SELECTED: assert property (@(posedge mclk) disable iff (!rst_n)
    !strobe_n |-> !select_n)
    else $error("strobe outside select");
  AST_LOAD_WITH_STROBE: assert property (@(posedge mclk) disable iff (!rst_n)
    !transfer_load_n |-> !strobe_n)
    else $error("load without strobe");
  AST_ADDR_STABLE: assert property (@(posedge mclk) disable iff (!rst_n)
    (!strobe_n && $past(!strobe_n)) |-> $stable(addr) && $stable(data_out))
    else $error("address moved during strobe");
  AST_PULSE_WIDTH: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(strobe_n) |-> !strobe_n [*2])
    else $error("strobe too short");
  AST_HOLD_AFTER: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(strobe_n) |-> !select_n && $stable(addr))
    else $error("no hold after strobe");
  AST_CLEAR_WIDTH: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(clear_outputs_n) |-> !clear_outputs_n [*2] ##1 clear_outputs_n)
    else $error("clear pulse width wrong");
endmodule

// [tb/mdl_dev_model.sv]
/* Model of the 16-channel converter load port.
   Assumes a host driving the select, strobe and bus pins. */
`timescale 1ns/1ps
module mdl_dev_model
  import mdl_pkg::*;
(
  input  wire logic                  select_n,
  input  wire logic                  strobe_n,
  input  wire logic                  read_write,
  input  wire logic                  transfer_load_n,
  input  wire logic                  clear_outputs_n,
  input  wire logic [MDL_ADDR_W-1:0] addr,
  input  wire logic [MDL_DATA_W-1:0] host_data,
  input  wire logic                  host_oe_n,
  output logic      [MDL_DATA_W-1:0] bus
);
  logic [MDL_DATA_W-1:0] in_reg [MDL_CHANNELS];
  logic [MDL_DATA_W-1:0] conv   [MDL_CHANNELS];
  logic [MDL_DATA_W-1:0] last;
  wire                   drive = !select_n && read_write;
  always @(posedge strobe_n)
    if (!select_n && !read_write) in_reg[addr] <= bus;
  always @(clear_outputs_n or select_n or strobe_n or transfer_load_n)
    if (!clear_outputs_n) conv = '{default: '0};
    else if (!select_n && !strobe_n && !transfer_load_n) conv = in_reg;
  // Released bus shows the inverse of its last value
  always @(host_data or host_oe_n or drive or addr)
    if (!host_oe_n) last = host_data;
    else if (drive) last = in_reg[addr];
  assign bus = !host_oe_n ? host_data : drive ? in_reg[addr] : ~last;
endmodule

// [tb/multi_channel_dac_load_port_tb_top.sv]
/* Bench for the load port host: writes, readback, common load, clear.
   Assumes the device model on the far side of the pins. */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
  fail_count++; $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module multi_channel_dac_load_port_tb_top;
  import mdl_pkg::*;
  logic           mclk = 1'b0;
  logic           rst_n, req_valid, req_ready, rsp_valid;
  mdl_op_t        req_op;
  logic [3:0]     req_addr, addr;
  logic [7:0]     req_data, rsp_data, data_out, bus, rd;
  logic           select_n, strobe_n, read_write, transfer_load_n, clear_outputs_n, data_oe_n;
  int             fail_count = 0;
  int             n_compared = 0;
  int             cycles = 0;

  mdl_host #(.STROBE_CYC(2)) dut (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .select_n(select_n), .strobe_n(strobe_n),
    .read_write(read_write), .transfer_load_n(transfer_load_n),
    .clear_outputs_n(clear_outputs_n), .addr(addr), .data_out(data_out),
    .data_oe_n(data_oe_n), .data_in(bus));
  mdl_dev_model dev (.select_n(select_n), .strobe_n(strobe_n), .read_write(read_write),
    .transfer_load_n(transfer_load_n), .clear_outputs_n(clear_outputs_n), .addr(addr),
    .host_data(data_out), .host_oe_n(data_oe_n), .bus(bus));

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  function automatic logic [7:0] code(int i);
    return {4'(i), ~4'(i)};
  endfunction

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic op(input mdl_op_t o, input logic [3:0] a, input logic [7:0] d);
    rd = 'x;
    @(posedge mclk);
    req_op <= o;
    req_addr <= a;
    req_data <= d;
    req_valid <= 1'b1;
    do @(negedge mclk); while (req_ready !== 1'b1);
    @(posedge mclk);
    req_valid <= 1'b0;
    do begin
      @(negedge mclk);
      if (rsp_valid === 1'b1) rd = rsp_data;
    end while (req_ready !== 1'b1);
  endtask

  task automatic t_clear;
    op(MDL_OP_CLEAR, 4'h0, 8'h00);
    for (int i = 0; i < 16; i++) `CHK("conv", MDL_CLEAR_CODE, dev.conv[i])
  endtask

  task automatic t_write_read;
    for (int i = 0; i < 16; i++) op(MDL_OP_WRITE, 4'(i), code(i));
    for (int i = 0; i < 16; i++) `CHK("staged", code(i), dev.in_reg[i])
    for (int i = 0; i < 16; i++) `CHK("conv", 8'h00, dev.conv[i])
    for (int i = 0; i < 16; i++) begin
      op(MDL_OP_READ, 4'(i), 8'h00);
      `CHK("readback", code(i), rd)
    end
  endtask

  task automatic t_load;
    op(MDL_OP_LOAD, 4'h0, 8'h00);
    for (int i = 0; i < 16; i++) `CHK("conv", code(i), dev.conv[i])
  endtask

  task automatic t_rewrite;
    op(MDL_OP_WRITE, 4'h5, 8'h3C);
    `CHK("conv5", code(5), dev.conv[5])
    for (int i = 0; i < 16; i++) begin
      op(MDL_OP_READ, 4'(i), 8'h00);
      `CHK("readback", (i == 5) ? 8'h3C : code(i), rd)
    end
  endtask

  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_op = MDL_OP_WRITE;
    req_addr = 4'h0;
    req_data = 8'h00;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    t_clear();
    t_write_read();
    t_load();
    t_rewrite();
    t_clear();
    op(MDL_OP_READ, 4'h5, 8'h00);
    `CHK("kept", 8'h3C, rd)
    close_out();
  end
endmodule
